// ### bench/pmc_ctrl_test.sv
// Self-checking testbench of the power mode controller.
`timescale 1ns/100ps
`default_nettype none
module pmc_ctrl_test;
    // ==========================================
    // Stimulus and observed signals
    logic                i_mclk    = 1'b0;
    logic                i_reset   = 1'b1;
    logic                ce        = 1'b1;
    logic [3:0]          addr      = 4'h0;
    logic [7:0]          wdata     = 8'h00;
    logic                wr        = 1'b0;
    logic                rd        = 1'b0;
    logic                sleep_req = 1'b0;
    logic                arm       = 1'b0;
    logic                ext       = 1'b0;
    logic                pend      = 1'b0;
    logic                stray     = 1'b0;
    logic [7:0]          rdata;
    pmc_pkg::pmc_power_t power;
    pmc_pkg::pmc_wake_t  wake;
    logic                core_run;
    logic                timer_en;
    logic                usb_reset;
    logic                retain;
    logic [1:0]          mode;
    logic                fault;
    int                  num_errors   = 0;
    int                  total_checks = 0;

    // Clock of 50 ns period.
    always #25 i_mclk = ~i_mclk;

    pmc_ctrl pmc_ctrl_i (.i_mclk(i_mclk), .i_reset(i_reset), .i_ce(ce), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .i_sleep_req(sleep_req), .i_wake(wake),
        .o_rdata(rdata), .o_power(power), .o_core_run(core_run),
        .o_sleep_timer_en(timer_en), .o_usb_reset(usb_reset), .o_sram_retain(retain),
        .o_mode(mode));
    pmc_partner pmc_partner_i (.i_mclk(i_mclk), .i_timer_en(timer_en), .i_arm(arm),
        .i_ext(ext), .i_pend(pend), .i_stray(stray), .i_power(power), .o_wake(wake),
        .o_fault(fault));

    // ==========================================
    // Shared tasks
    // Compares one value and counts the outcome.
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic report_and_stop();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // One-cycle register write.
    task automatic bus_write(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge i_mclk);
        wr <= 1'b0;
    endtask

    // One-cycle register read; data are judged in the following cycle.
    task automatic bus_read(input string what, input logic [3:0] a, input logic [7:0] exp);
        @(posedge i_mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge i_mclk);
        rd <= 1'b0;
        #1;
        chk(what, rdata, exp);
    endtask

    // Expected supply controls for a mode and a control byte.
    function automatic logic [7:0] exp_pw(input logic [1:0] m, input logic [7:0] c);
        logic fast;
        logic slow;
        fast = (m == 2'h0);
        slow = (m != 2'h3);
        return {3'h0, m < 2'h2, fast & c[2], fast & (c[3] | ~c[2]), slow & ~c[4], slow & c[4]};
    endfunction

    // Requests a sleep mode and judges the entry cycle.
    task automatic go_sleep(input logic [1:0] m, input logic [7:0] c);
        bus_write(4'h0, {c[7:2], m});
        @(posedge i_mclk);
        sleep_req <= 1'b1;
        @(posedge i_mclk);
        sleep_req <= 1'b0;
        #1;
        chk("mode", {6'h00, mode}, {6'h00, m});
        chk("core", {7'h00, core_run}, 8'h00);
        chk("power", {3'h0, power}, exp_pw(m, c));
        chk("timer", {7'h00, timer_en}, {7'h00, m != 2'h3});
        chk("usb", {7'h00, usb_reset}, {7'h00, m >= 2'h2});
        chk("retain", {7'h00, retain}, {7'h00, m >= 2'h2});
        @(posedge i_mclk);
        #1;
        chk("usb pulse", {7'h00, usb_reset}, 8'h00);
    endtask

    // Waits for the core release and judges the power-up order and timing.
    task automatic wake_wait(input int lo, input int hi, input logic [7:0] c);
        int n;
        int t_reg;
        int t_osc;
        n = 0;
        t_reg = 0;
        t_osc = 0;
        while (core_run !== 1'b1)
        begin
            @(posedge i_mclk);
            #1;
            n++;
            if (power.regulator_on === 1'b1 && t_reg == 0)
                t_reg = n;
            if ((power.crystal_oscillator | power.fast_rc_oscillator) === 1'b1 && t_osc == 0)
                t_osc = n;
            // A hang counts as a mismatch; the run goes on to the report.
            if (n > 300)
            begin
                num_errors++;
                break;
            end
        end
        chk("order", {7'h00, t_reg < t_osc && t_osc < n}, 8'h01);
        chk("latency", {7'h00, n >= lo && n <= hi}, 8'h01);
        chk("woken", {6'h00, mode}, 8'h00);
        chk("awake power", {3'h0, power}, exp_pw(2'h0, c));
        chk("awake retain", {6'h00, retain, timer_en}, 8'h01);
        bus_read("mode cleared", 4'h0, {c[7:2], 2'h0});
    endtask

    // ==========================================
    // Scenarios
    // Reset state, register map, refused writes and oscillator choice.
    task automatic t_regs();
        chk("reset power", {3'h0, power}, 8'h16);
        chk("reset flags", {4'h0, core_run, timer_en, usb_reset, retain}, 8'h0c);
        bus_read("ctrl", 4'h0, 8'h08);
        @(posedge i_mclk);
        #1;
        chk("rdata idle", rdata, 8'h00);
        bus_read("status", 4'h1, 8'h0c);
        bus_read("unmapped", 4'h7, 8'h00);
        bus_write(4'h7, 8'hff);
        @(posedge i_mclk);
        ce <= 1'b0;
        bus_write(4'h0, 8'h14);
        @(posedge i_mclk);
        ce <= 1'b1;
        bus_read("frozen", 4'h0, 8'h08);
        bus_write(4'h0, 8'he4);
        repeat (2) @(posedge i_mclk);
        #1;
        chk("crystal", {3'h0, power}, exp_pw(2'h0, 8'he4));
        bus_read("ctrl rw", 4'h0, 8'he4);
    endtask

    // Each sleep mode, left by an external interrupt.
    task automatic t_modes();
        logic [7:0] cs [3];
        cs = '{8'h08, 8'h14, 8'h1c};
        for (int m = 1; m <= 3; m++)
        begin
            go_sleep(m[1:0], cs[m - 1]);
            @(posedge i_mclk);
            ext <= 1'b1;
            @(posedge i_mclk);
            ext <= 1'b0;
            wake_wait(55, 75, cs[m - 1]);
        end
    endtask

    // Light and regulator-off sleep left by a sleep timer expiry.
    task automatic t_timer();
        for (int m = 1; m <= 2; m++)
        begin
            go_sleep(m[1:0], 8'h0c);
            @(posedge i_mclk);
            arm <= 1'b1;
            @(posedge i_mclk);
            arm <= 1'b0;
            wake_wait(62, 90, 8'h0c);
        end
    endtask

    // Deepest sleep ignores the timer, then a pending interrupt wakes it.
    task automatic t_deep();
        go_sleep(2'h3, 8'h08);
        @(posedge i_mclk);
        stray <= 1'b1;
        repeat (80) @(posedge i_mclk);
        stray <= 1'b0;
        #1;
        chk("deep kept", {5'h00, core_run, mode}, 8'h03);
        @(posedge i_mclk);
        pend <= 1'b1;
        wake_wait(55, 80, 8'h08);
        @(posedge i_mclk);
        pend <= 1'b0;
    endtask

    // Sleep requests with mode zero or beside a wake source are ignored.
    task automatic t_refuse();
        bus_write(4'h0, 8'h08);
        @(posedge i_mclk);
        sleep_req <= 1'b1;
        @(posedge i_mclk);
        sleep_req <= 1'b0;
        bus_write(4'h0, 8'h09);
        @(posedge i_mclk);
        sleep_req <= 1'b1;
        ext <= 1'b1;
        @(posedge i_mclk);
        sleep_req <= 1'b0;
        ext <= 1'b0;
        repeat (2) @(posedge i_mclk);
        #1;
        chk("no sleep", {5'h00, core_run, mode}, 8'h04);
    endtask

    // ==========================================
    // Main sequence
    initial
    begin
        repeat (6) @(posedge i_mclk);
        i_reset <= 1'b0;
        @(posedge i_mclk);
        #1;
        t_regs();
        t_modes();
        t_timer();
        t_deep();
        t_refuse();
        chk("supply", {7'h00, fault}, 8'h00);
        report_and_stop();
    end
endmodule
`default_nettype wire

// ### bench/pmc_partner.sv
// Behavioural model of the sleep timer, wake sources and oscillator supply.
`timescale 1ns/100ps
`default_nettype none
module pmc_partner
(
    input  wire logic                i_mclk,
    input  wire logic                i_timer_en,
    input  wire logic                i_arm,
    input  wire logic                i_ext,
    input  wire logic                i_pend,
    input  wire logic                i_stray,
    input  wire pmc_pkg::pmc_power_t i_power,
    output pmc_pkg::pmc_wake_t       o_wake,
    output logic                     o_fault
);
    // ==========================================
    // Sleep timer
    // Count loaded by the arm pulse; it only runs while enabled.
    logic [7:0] count = 8'h00;

    // Load on arm, else count down while the design lets the timer run.
    always @(posedge i_mclk)
    begin
        if (i_arm)
            count <= 8'h0a;
        else if (i_timer_en && count != 8'h00)
            count <= count - 8'h01;
    end

    // The stray input fakes an expiry that a halted timer could not make.
    assign o_wake.timer_expiry = (count == 8'h01 && i_timer_en) || i_stray;
    assign o_wake.ext_irq      = i_ext;
    assign o_wake.irq_pending  = i_pend;

    // ==========================================
    // Supply watch
    // A fast oscillator cannot start without the core regulator.
    logic fault = 1'b0;  // Sticky supply fault, one driver only.

    // Latch a fault once a fast oscillator runs unpowered.
    always @(posedge i_mclk)
    begin
        if ((i_power.crystal_oscillator || i_power.fast_rc_oscillator) && !i_power.regulator_on)
        begin
            fault <= 1'b1;
        end
    end

    assign o_fault = fault;
endmodule
`default_nettype wire

// ### verilog/pmc_cfg.svh
// Constants of the power mode controller: timing counts and control fields.
`ifndef PMC_CFG_SVH
`define PMC_CFG_SVH
// Clock period in nanoseconds of i_mclk.
`define PMC_CLK_NS            50
// Least regulator settling time in nanoseconds before oscillators start.
`define PMC_REG_SETTLE_NS     1000
// Least oscillator start-up time in nanoseconds before the core is released.
`define PMC_OSC_SETTLE_NS     2000
// Settle counts in cycles, rounded up.
`define PMC_REG_SETTLE_CYC    ((`PMC_REG_SETTLE_NS + `PMC_CLK_NS - 1) / `PMC_CLK_NS)
`define PMC_OSC_SETTLE_CYC    ((`PMC_OSC_SETTLE_NS + `PMC_CLK_NS - 1) / `PMC_CLK_NS)
// Register offsets.
`define PMC_ADDR_CTRL         4'h0
`define PMC_ADDR_STATUS       4'h1
// Control register fields.
`define PMC_CTRL_MODE_LSB     0
`define PMC_CTRL_HS_XTAL_BIT  2
`define PMC_CTRL_HS_RC_BIT    3
`define PMC_CTRL_LS_XTAL_BIT  4
// Reset value of the control register: fast RC and slow RC chosen.
`define PMC_CTRL_RESET        8'h08
`endif

// ### verilog/pmc_ctrl.sv
// Power mode controller: selects regulator and oscillators per power mode.
// How it works
// - Four ordered modes, active zero, deepest three.
// - Active mode: regulator on, fast oscillator running.
// - Modes zero to two keep one slow clock.
// - Light sleep: regulator on, fast oscillators stopped.
// - Light and regulator-off sleep wake on events.
// - Regulator-off sleep: regulator off, slow clock runs.
// - Deepest sleep: all off, reset or interrupt wakes.
// - Entering modes two or three clears USB.
// - Data SRAM retention held in modes two, three.
// - Sleep timer runs except in deepest mode.
// - Pending interrupt wakes any sleep mode first.
//
// The address-and-strobe port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "pmc_cfg.svh"
module pmc_ctrl
#(
    parameter int SETTLE_W = 8
)
(
    input  wire logic              i_mclk,
    input  wire logic              i_reset,
    input  wire logic              i_ce,
    input  wire logic [3:0]        i_addr,
    input  wire logic [7:0]        i_wdata,
    input  wire logic              i_wr,
    input  wire logic              i_rd,
    input  wire logic              i_sleep_req,
    input  wire pmc_pkg::pmc_wake_t i_wake,
    output logic [7:0]             o_rdata,
    output pmc_pkg::pmc_power_t    o_power,
    output logic                   o_core_run,
    output logic                   o_sleep_timer_en,
    output logic                   o_usb_reset,
    output logic                   o_sram_retain,
    output logic [1:0]             o_mode
);
    // =====================================================================
    // State
    // =====================================================================
    typedef enum logic [1:0] {
        SEQ_RUN,
        SEQ_SLEEP,
        SEQ_REG_UP,
        SEQ_OSC_UP
    } pmc_seq_t;

    typedef struct packed {
        pmc_seq_t            seq;      // Sequencer step.
        pmc_pkg::pmc_mode_t  mode;     // Present power mode.
        logic [7:0]          ctrl;     // Control register.
        logic [7:0]          rdata;    // Read data register.
        pmc_pkg::pmc_power_t power;    // Analog enables.
        logic                core_run; // Core clock released.
        logic                tmr_en;   // Sleep timer enable.
        logic                usb_rst;  // USB state clear.
        logic                retain;   // SRAM retention enable.
        logic                load;     // Settle counter load pulse.
        logic [SETTLE_W-1:0] count;    // Settle count to load.
    } pmc_state_t;

    pmc_state_t st;       // Registered state.
    pmc_state_t next_st;  // Next state.
    logic       settled;  // Settle delay elapsed.

    // Settle counts cut to the counter width; the check below keeps them whole.
    localparam logic [SETTLE_W-1:0] REG_CYC = SETTLE_W'(`PMC_REG_SETTLE_CYC);
    localparam logic [SETTLE_W-1:0] OSC_CYC = SETTLE_W'(`PMC_OSC_SETTLE_CYC);

    // Refuse a counter too narrow to hold either settle count.
    if ((`PMC_OSC_SETTLE_CYC >= (1 << SETTLE_W)) || (`PMC_REG_SETTLE_CYC >= (1 << SETTLE_W))
        || (`PMC_REG_SETTLE_CYC < 1))
    begin : g_bad_width
        $error("pmc_ctrl: SETTLE_W too narrow for settle counts.");
    end

    // Builds the enables for a mode from the selected oscillators.
    function automatic pmc_pkg::pmc_power_t mode_power(input pmc_pkg::pmc_mode_t m,
                                                        input logic [7:0] c);
        pmc_pkg::pmc_power_t p;
        logic                fast_any;
        p        = '0;
        fast_any = c[`PMC_CTRL_HS_XTAL_BIT] | c[`PMC_CTRL_HS_RC_BIT];
        // Regulator is on in active and light sleep only.
        p.regulator_on = (m == pmc_pkg::PMC_ACTIVE) || (m == pmc_pkg::PMC_LIGHT);
        if (m == pmc_pkg::PMC_ACTIVE)
        begin
            // Fast RC is forced on if firmware picked neither fast source.
            p.crystal_oscillator = c[`PMC_CTRL_HS_XTAL_BIT];
            p.fast_rc_oscillator = c[`PMC_CTRL_HS_RC_BIT] | ~fast_any;
        end
        if (m != pmc_pkg::PMC_DEEPEST)
        begin
            // Exactly one slow clock runs.
            p.watch_crystal      = c[`PMC_CTRL_LS_XTAL_BIT];
            p.slow_rc_oscillator = ~c[`PMC_CTRL_LS_XTAL_BIT];
        end
        return p;
    endfunction

    // =====================================================================
    // Settle delay counter
    // =====================================================================
    pmc_settle #(
        .WIDTH (SETTLE_W)
    ) u_settle (
        .i_mclk  (i_mclk),
        .i_reset (i_reset),
        .i_ce    (i_ce),
        .i_load  (st.load),
        .i_count (st.count),
        .o_done  (settled)
    );

    // =====================================================================
    // Next state
    // =====================================================================
    // Register port, sleep entry and the staged wake-up sequence.
    always_comb
    begin
        logic wake;
        logic deep_wake;
        logic [1:0] req_mode;
        wake      = i_wake.ext_irq | i_wake.timer_expiry | i_wake.irq_pending;
        deep_wake = i_wake.ext_irq | i_wake.irq_pending;
        req_mode  = st.ctrl[`PMC_CTRL_MODE_LSB +: 2];
        next_st         = st;
        next_st.load    = 1'b0;
        next_st.usb_rst = 1'b0;
        next_st.rdata   = 8'h00;
        // Register reads: data appear one cycle after the strobe.
        if (i_rd)
        begin
            if (i_addr == `PMC_ADDR_CTRL)
            begin
                next_st.rdata = st.ctrl;
            end
            else if (i_addr == `PMC_ADDR_STATUS)
            begin
                next_st.rdata = {4'h0, st.core_run, st.power.regulator_on, st.mode};
            end
        end
        // Control writes; unmapped addresses are ignored.
        if (i_wr && (i_addr == `PMC_ADDR_CTRL))
        begin
            next_st.ctrl = i_wdata;
        end
        unique case (st.seq)
            SEQ_RUN:
            begin
                // Oscillator choice in active mode follows the control register.
                next_st.power = mode_power(pmc_pkg::PMC_ACTIVE, st.ctrl);
                // Sleep only on an explicit request to a sleep mode.
                if (i_sleep_req && (req_mode != 2'h0) && !wake)
                begin
                    next_st.mode     = pmc_pkg::pmc_mode_t'(req_mode);
                    next_st.seq      = SEQ_SLEEP;
                    next_st.core_run = 1'b0;
                    next_st.power    = mode_power(pmc_pkg::pmc_mode_t'(req_mode), st.ctrl);
                    next_st.tmr_en   = (req_mode != 2'h3);
                    next_st.usb_rst  = req_mode[1];
                    next_st.retain   = req_mode[1];
                end
            end
            SEQ_SLEEP:
            begin
                // Deepest sleep has no timer, so only interrupts wake it.
                if ((st.mode == pmc_pkg::PMC_DEEPEST) ? deep_wake : wake)
                begin
                    next_st.power.regulator_on = 1'b1;
                    next_st.seq   = SEQ_REG_UP;
                    next_st.load  = 1'b1;
                    next_st.count = REG_CYC;
                end
            end
            SEQ_REG_UP:
            begin
                // Regulator settled: start the active mode oscillators.
                if (settled && !st.load)
                begin
                    next_st.power = mode_power(pmc_pkg::PMC_ACTIVE, st.ctrl);
                    next_st.seq   = SEQ_OSC_UP;
                    next_st.load  = 1'b1;
                    next_st.count = OSC_CYC;
                end
            end
            SEQ_OSC_UP:
            begin
                // Oscillators stable: release the core in active mode.
                if (settled && !st.load)
                begin
                    next_st.seq      = SEQ_RUN;
                    next_st.mode     = pmc_pkg::PMC_ACTIVE;
                    next_st.core_run = 1'b1;
                    next_st.tmr_en   = 1'b1;
                    next_st.retain   = 1'b0;
                    next_st.ctrl[`PMC_CTRL_MODE_LSB +: 2] = 2'h0;
                end
            end
        endcase
    end

    // =====================================================================
    // Registers
    // =====================================================================
    // Reset returns to active mode with default oscillators.
    always_ff @(posedge i_mclk)
    begin
        if (i_reset)
        begin
            st          <= '0;
            st.seq      <= SEQ_RUN;
            st.mode     <= pmc_pkg::PMC_ACTIVE;
            st.ctrl     <= `PMC_CTRL_RESET;
            st.power    <= '{regulator_on: 1'b1, crystal_oscillator: 1'b0,
                             fast_rc_oscillator: 1'b1, slow_rc_oscillator: 1'b1,
                             watch_crystal: 1'b0};
            st.core_run <= 1'b1;
            st.tmr_en   <= 1'b1;
        end
        else if (i_ce)
        begin
            st <= next_st;
        end
    end

    assign o_rdata          = st.rdata;
    assign o_power          = st.power;
    assign o_core_run       = st.core_run;
    assign o_sleep_timer_en = st.tmr_en;
    assign o_usb_reset      = st.usb_rst;
    assign o_sram_retain    = st.retain;
    assign o_mode           = st.mode;

    // =====================================================================
    // Checks
    // =====================================================================
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_reset);

    // A sleep request taken in run with the enable high.
    sequence s_sleep_entry;
        (st.seq == SEQ_RUN) && i_ce && i_sleep_req;
    endsequence

    // First cycle of the regulator settle step.
    sequence s_wake_start;
        (st.seq == SEQ_SLEEP) ##1 (st.seq == SEQ_REG_UP);
    endsequence

    // First cycle of the oscillator settle step.
    sequence s_osc_start;
        (st.seq == SEQ_REG_UP) ##1 (st.seq == SEQ_OSC_UP);
    endsequence

    // Supply levels, USB clear, SRAM retention and timer enable in each mode.
    chk_active_reg_on: assert property (o_core_run |-> o_power.regulator_on)
        else $error("Core runs without regulator.");
    chk_active_fast_osc: assert property (o_core_run |->
        (o_power.crystal_oscillator || o_power.fast_rc_oscillator))
        else $error("Active mode without fast oscillator.");
    chk_slow_clock_one: assert property ((o_mode != 2'h3) |->
        (o_power.slow_rc_oscillator ^ o_power.watch_crystal))
        else $error("Slow clock not exactly one.");
    chk_light_sleep_power: assert property ((st.seq == SEQ_SLEEP && o_mode == 2'h1)
        |-> (o_power.regulator_on && !o_power.crystal_oscillator
         && !o_power.fast_rc_oscillator))
        else $error("Light sleep power wrong.");
    chk_reg_off_power: assert property ((st.seq == SEQ_SLEEP && o_mode == 2'h2)
        |-> (!o_power.regulator_on && !o_power.crystal_oscillator
         && !o_power.fast_rc_oscillator))
        else $error("Regulator-off sleep power wrong.");
    chk_deep_all_off: assert property ((st.seq == SEQ_SLEEP && o_mode == 2'h3)
        |-> (o_power == '0 && !o_sleep_timer_en))
        else $error("Deepest sleep not all off.");
    chk_usb_clear_entry: assert property (s_sleep_entry ##1
        ((st.seq == SEQ_SLEEP) && o_mode[1]) |-> (o_usb_reset && o_sram_retain))
        else $error("USB not cleared on deep entry.");
    chk_usb_pulse_one: assert property ((o_usb_reset && i_ce) |=> !o_usb_reset)
        else $error("USB clear longer than one cycle.");
    chk_sram_kept: assert property ((st.seq != SEQ_RUN && o_mode[1]) |-> o_sram_retain)
        else $error("Data SRAM not retained in deep sleep.");
    chk_timer_runs: assert property ((o_mode != 2'h3) |-> o_sleep_timer_en)
        else $error("Sleep timer stopped outside deepest sleep.");

    // Wake sources and the power-up order.
    chk_wake_starts: assert property (
        (st.seq == SEQ_SLEEP && i_ce && i_wake.ext_irq)
        |=> (st.seq == SEQ_REG_UP && o_power.regulator_on))
        else $error("Interrupt did not start wake-up.");
    chk_timer_wakes: assert property (
        (st.seq == SEQ_SLEEP && o_mode != 2'h3 && i_ce && i_wake.timer_expiry)
        |=> (st.seq == SEQ_REG_UP))
        else $error("Timer expiry did not start wake-up.");
    chk_deep_ignores_timer: assert property (
        (st.seq == SEQ_SLEEP && o_mode == 2'h3 && !i_wake.ext_irq && !i_wake.irq_pending)
        |=> (st.seq == SEQ_SLEEP))
        else $error("Deepest sleep left without interrupt.");
    chk_wake_reg_up: assert property (s_wake_start |->
        (o_power.regulator_on && !o_core_run && (o_mode != 2'h0)))
        else $error("Wake-up did not power the regulator first.");
    chk_reg_before_osc: assert property ((st.seq == SEQ_REG_UP) |->
        (o_power.regulator_on && !o_power.crystal_oscillator
         && !o_power.fast_rc_oscillator))
        else $error("Fast oscillator started before regulator settled.");
    chk_osc_before_core: assert property (s_osc_start |->
        ((o_power.crystal_oscillator || o_power.fast_rc_oscillator) && !o_core_run))
        else $error("Oscillators not started before core release.");
    chk_core_after_power: assert property ($rose(o_core_run) |->
        (($past(st.seq) == SEQ_OSC_UP) && o_power.regulator_on))
        else $error("Core released before power up.");
endmodule
`default_nettype wire

// ### verilog/pmc_pkg.sv
// Types shared by the power mode controller files.
`default_nettype none
package pmc_pkg;
    // Power modes from active to deepest.
    typedef enum logic [1:0] {
        PMC_ACTIVE    = 2'h0,
        PMC_LIGHT     = 2'h1,
        PMC_REG_OFF   = 2'h2,
        PMC_DEEPEST   = 2'h3
    } pmc_mode_t;

    // Controls driven out to the analog parts.
    typedef struct packed {
        logic regulator_on;      // Digital core regulator enable.
        logic crystal_oscillator;  // Fast crystal oscillator enable.
        logic fast_rc_oscillator;  // Fast RC oscillator enable.
        logic slow_rc_oscillator;  // Slow RC oscillator enable.
        logic watch_crystal;     // Watch crystal oscillator enable.
    } pmc_power_t;

    // Wake sources.
    typedef struct packed {
        logic ext_irq;           // External interrupt pin event.
        logic timer_expiry;      // Sleep timer expiry.
        logic irq_pending;       // Any pending interrupt request.
    } pmc_wake_t;
endpackage
`default_nettype wire

// ### verilog/pmc_settle.sv
// Down counter that signals when a settling delay has run out.
`timescale 1ns/100ps
`default_nettype none
module pmc_settle
#(
    parameter int WIDTH = 8
)
(
    input  wire logic             i_mclk,
    input  wire logic             i_reset,
    input  wire logic             i_ce,
    input  wire logic             i_load,
    input  wire logic [WIDTH-1:0] i_count,
    output logic                  o_done
);
    // =====================================================================
    // State
    // =====================================================================
    typedef struct packed {
        logic [WIDTH-1:0] cnt;   // Remaining cycles.
        logic             done;  // High once the count is down to one.
    } pmc_settle_state_t;

    pmc_settle_state_t st;       // Registered state.
    pmc_settle_state_t next_st;  // Next state.

    // Refuse a width that leaves no room to count.
    if (WIDTH < 2)
    begin : g_bad_width
        $error("pmc_settle: WIDTH must be at least 2.");
    end

    // Load restarts the delay; otherwise count down to one and flag done.
    always_comb
    begin
        next_st = st;
        if (i_load)
        begin
            next_st.cnt  = i_count;
            next_st.done = 1'b0;
        end
        else if (st.cnt > {{(WIDTH-1){1'b0}}, 1'b1})
        begin
            next_st.cnt = st.cnt - {{(WIDTH-1){1'b0}}, 1'b1};
        end
        else
        begin
            next_st.done = 1'b1;
        end
    end

    // Register the state when enabled.
    always_ff @(posedge i_mclk)
    begin
        if (i_reset)
        begin
            st <= '{cnt: '0, done: 1'b1};
        end
        else if (i_ce)
        begin
            st <= next_st;
        end
    end

    assign o_done = st.done;
endmodule
`default_nettype wire
